// ===== shared/scfs_pkg.sv
/*
  Package for the serial configuration and status frame block: frame
  layout, configuration field positions, reset values and filter counts.
  Assumes a 16-bit frame shifted most significant bit first.
*/
`default_nettype none

package scfs_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;
  localparam logic [4:0]  FRAME_LEN  = 5'h10;

  // configuration input frame fields
  localparam int unsigned CFG_KIND_BIT    = 0;
  localparam int unsigned CFG_STATUS_FRAME_REQUEST_BIT    = 1;
  localparam int unsigned CFG_SLEEP_BIT   = 2;
  localparam int unsigned CFG_SPEED_BIT   = 3;
  localparam int unsigned CFG_STYLE_BIT   = 4;
  localparam int unsigned CFG_FILTER_BIT  = 5;
  localparam int unsigned CFG_SEL_LSB     = 6;
  localparam int unsigned CFG_SEL_MSB     = 7;
  localparam int unsigned CFG_ATEST_BIT   = 8;
  localparam int unsigned CFG_CAL_LSB     = 9;
  localparam int unsigned CFG_CAL_MSB     = 13;

  // calibration selector values
  localparam logic [1:0] CAL_A_GAIN   = 2'h0;
  localparam logic [1:0] CAL_A_OFFSET = 2'h1;
  localparam logic [1:0] CAL_B_GAIN   = 2'h2;
  localparam logic [1:0] CAL_B_OFFSET = 2'h3;

  // output frame fields
  localparam int unsigned OUT_KIND_BIT = 7;
  localparam logic [5:0]  INFO_MARK    = 6'h06;

  // reset values
  localparam logic [4:0]  CAL_RESET = 5'h00;
  localparam logic        CFG_RESET = 1'b0;

  // encoder filter lengths in rising serial clock edges
  localparam logic [2:0] FILT_SHORT = 3'h2;
  localparam logic [2:0] FILT_LONG  = 3'h4;

  typedef enum logic {
    SCFS_IDLE  = 1'b0,
    SCFS_SHIFT = 1'b1
  } scfs_state_t;

endpackage : scfs_pkg

`default_nettype wire

// ===== rtl/scfs_frame.sv
/*
  Serial frame engine: shifts 16-bit input frames in, decodes configuration
  frames, and returns normal or information frames to the host.
  Assumes the serial pins are asynchronous to clock_i and that the serial
  clock is much slower than clock_i; converter and status inputs are
  synchronous to clock_i.
*/
`timescale 1ns/100ps
`default_nettype none

module scfs_frame (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // serial pins
  input  wire logic       serial_clk_i,
  input  wire logic       chip_en_n_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  output logic            miso_oe_n_o,
  // converter side
  input  wire logic [7:0] conversion_result_i,
  input  wire logic [2:0] conversion_source_i,
  input  wire logic       first_conversion_complete_i,
  input  wire logic       second_conversion_complete_i,
  // raw encoder phases from the analog stage
  input  wire logic       encoder_phase_a_i,
  input  wire logic       encoder_phase_b_i,
  // status flags
  input  wire logic       external_reset_flag_i,
  input  wire logic       input_supply_low_flag_i,
  input  wire logic       five_volt_rail_low_i,
  input  wire logic       three_volt_rail_low_i,
  input  wire logic       core_rail_low_i,
  input  wire logic       overheat_trip_flag_i,
  input  wire logic       overheat_warn_flag_i,
  // configuration and filtered encoder outputs
  output logic [4:0]      cal_a_gain_o,
  output logic [4:0]      cal_a_offset_o,
  output logic [4:0]      cal_b_gain_o,
  output logic [4:0]      cal_b_offset_o,
  output logic            encoder_filter_long_o,
  output logic            motor_c_style_o,
  output logic            low_side_aux_output_en_o,
  output logic            high_side_aux_output_en_o,
  output logic            conversion_slow_o,
  output logic            power_down_o,
  output logic            analog_test_route_o,
  output logic            encoder_phase_a_o,
  output logic            encoder_phase_b_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]           sclk_s;
    logic [2:0]           ce_s;
    logic [2:0]           mosi_s;
    logic [1:0][2:0]      enc_s;
    logic                 sclk_q;
    logic                 ce_q;
    scfs_pkg::scfs_state_t st;
    logic [4:0]           bit_cnt;
    logic [15:0]          rx;
    logic [15:0]          tx;
    logic                 miso;
    logic [3:0][4:0]      cal;
    logic                 filt_long;
    logic                 style;
    logic                 slow;
    logic                 pdown;
    logic                 atest;
    logic                 info_pend;
    logic                 done1_pend;
    logic                 done2_pend;
    logic [1:0]           enc_q;
    logic [1:0][2:0]      enc_cnt;
  } scfs_reg_t;

  scfs_reg_t r;
  scfs_reg_t next_r;

  logic       sclk_rise;
  logic       sclk_fall;
  logic       frame_start;
  logic       frame_end;
  logic       cfg_decode;
  logic [2:0] filt_len;
  logic [1:0] enc_raw;

  // a change counts only once stages two and three agree
  assign sclk_rise   = (r.sclk_s[1] == r.sclk_s[2]) && r.sclk_s[2] && !r.sclk_q;
  assign sclk_fall   = (r.sclk_s[1] == r.sclk_s[2]) && !r.sclk_s[2] && r.sclk_q;
  assign frame_start = (r.ce_s[1] == r.ce_s[2]) && !r.ce_s[2] && r.ce_q;
  assign frame_end   = (r.ce_s[1] == r.ce_s[2]) && r.ce_s[2] && !r.ce_q;
  // short or long frames are dropped whole
  assign cfg_decode  = frame_end && (r.bit_cnt == scfs_pkg::FRAME_LEN)
                       && r.rx[scfs_pkg::CFG_KIND_BIT];
  assign filt_len    = r.filt_long ? scfs_pkg::FILT_LONG : scfs_pkg::FILT_SHORT;
  assign enc_raw     = {r.enc_s[1][2], r.enc_s[0][2]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.sclk_s = {r.sclk_s[1:0], serial_clk_i};
    next_r.ce_s   = {r.ce_s[1:0], chip_en_n_i};
    next_r.mosi_s = {r.mosi_s[1:0], mosi_i};
    next_r.enc_s[0] = {r.enc_s[0][1:0], encoder_phase_a_i};
    next_r.enc_s[1] = {r.enc_s[1][1:0], encoder_phase_b_i};
    if (r.sclk_s[1] == r.sclk_s[2]) begin
      next_r.sclk_q = r.sclk_s[2];
    end
    if (r.ce_s[1] == r.ce_s[2]) begin
      next_r.ce_q = r.ce_s[2];
    end

    // encoder filter: a new level must hold for filt_len rising serial clock edges
    for (int i = 0; i < 2; i++) begin
      if (sclk_rise && (r.enc_s[i][1] == r.enc_s[i][2])) begin
        if (enc_raw[i] == r.enc_q[i]) begin
          next_r.enc_cnt[i] = 3'h0;
        end else if (r.enc_cnt[i] + 3'h1 >= filt_len) begin
          next_r.enc_q[i]   = enc_raw[i];
          next_r.enc_cnt[i] = 3'h0;
        end else begin
          next_r.enc_cnt[i] = r.enc_cnt[i] + 3'h1;
        end
      end
    end

    // done events wait for the next normal frame
    if (first_conversion_complete_i) begin
      next_r.done1_pend = 1'b1;
    end
    if (second_conversion_complete_i) begin
      next_r.done2_pend = 1'b1;
    end

    case (r.st)
      scfs_pkg::SCFS_IDLE: begin
        if (frame_start) begin
          next_r.st      = scfs_pkg::SCFS_SHIFT;
          next_r.bit_cnt = 5'h00;
          if (r.info_pend) begin
            next_r.tx = {scfs_pkg::INFO_MARK,
                         external_reset_flag_i, input_supply_low_flag_i,
                         1'b1,
                         five_volt_rail_low_i, three_volt_rail_low_i,
                         core_rail_low_i,
                         r.enc_q[1], r.enc_q[0],
                         overheat_trip_flag_i, overheat_warn_flag_i};
            // cleared outright; requests are only set in SCFS_SHIFT, never in this cycle
            next_r.info_pend = 1'b0;
          end else begin
            next_r.tx = {conversion_result_i,
                         1'b0,
                         conversion_source_i,
                         r.enc_q[1], r.enc_q[0],
                         r.done2_pend, r.done1_pend};
            // flags leave after one frame; a fresh event wins over the clear
            next_r.done1_pend = first_conversion_complete_i;
            next_r.done2_pend = second_conversion_complete_i;
          end
          // first bit must stand before the host's first serial clock rise
          next_r.miso = next_r.tx[15];
        end
      end
      scfs_pkg::SCFS_SHIFT: begin
        if (sclk_rise) begin
          next_r.rx = {r.rx[14:0], r.mosi_s[2]};
          if (r.bit_cnt != 5'h1f) begin
            next_r.bit_cnt = r.bit_cnt + 5'h01;
          end
        end
        if (sclk_fall) begin
          next_r.tx   = {r.tx[14:0], 1'b0};
          next_r.miso = r.tx[14];
        end
        if (frame_end) begin
          next_r.st = scfs_pkg::SCFS_IDLE;
        end
        if (cfg_decode) begin
          // test bits 15..14 carry no function here
          next_r.cal[r.rx[scfs_pkg::CFG_SEL_MSB:scfs_pkg::CFG_SEL_LSB]] =
            r.rx[scfs_pkg::CFG_CAL_MSB:scfs_pkg::CFG_CAL_LSB];
          next_r.atest     = r.rx[scfs_pkg::CFG_ATEST_BIT];
          next_r.filt_long = r.rx[scfs_pkg::CFG_FILTER_BIT];
          next_r.style     = r.rx[scfs_pkg::CFG_STYLE_BIT];
          next_r.slow      = r.rx[scfs_pkg::CFG_SPEED_BIT];
          next_r.pdown     = r.rx[scfs_pkg::CFG_SLEEP_BIT];
          if (r.rx[scfs_pkg::CFG_STATUS_FRAME_REQUEST_BIT]) begin
            next_r.info_pend = 1'b1;
          end
        end
      end
      default: begin
        next_r.st = scfs_pkg::SCFS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r            <= '0;
      r.sclk_s     <= 3'h0;
      r.ce_s       <= 3'h7;
      r.ce_q       <= 1'b1;
      r.st         <= scfs_pkg::SCFS_IDLE;
      r.cal        <= {4{scfs_pkg::CAL_RESET}};
      r.filt_long  <= scfs_pkg::CFG_RESET;
      r.style      <= scfs_pkg::CFG_RESET;
      r.slow       <= scfs_pkg::CFG_RESET;
      r.pdown      <= scfs_pkg::CFG_RESET;
      r.atest      <= scfs_pkg::CFG_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign miso_o                    = r.miso;
  // release the shared return line whenever this device is not selected
  assign miso_oe_n_o               = (r.st != scfs_pkg::SCFS_SHIFT);
  assign cal_a_gain_o              = r.cal[scfs_pkg::CAL_A_GAIN];
  assign cal_a_offset_o            = r.cal[scfs_pkg::CAL_A_OFFSET];
  assign cal_b_gain_o              = r.cal[scfs_pkg::CAL_B_GAIN];
  assign cal_b_offset_o            = r.cal[scfs_pkg::CAL_B_OFFSET];
  assign encoder_filter_long_o     = r.filt_long;
  assign motor_c_style_o           = r.style;
  assign low_side_aux_output_en_o  = r.style;
  assign high_side_aux_output_en_o = !r.style;
  assign conversion_slow_o         = r.slow;
  assign power_down_o              = r.pdown;
  assign analog_test_route_o       = r.atest;
  assign encoder_phase_a_o         = r.enc_q[0];
  assign encoder_phase_b_o         = r.enc_q[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  info_kind_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (r.st == scfs_pkg::SCFS_IDLE && frame_start) |=>
      (r.tx[scfs_pkg::OUT_KIND_BIT] == $past(r.info_pend)))
    else $error("frame kind bit disagrees with request");

  info_mark_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (r.st == scfs_pkg::SCFS_IDLE && frame_start && r.info_pend) |=>
      (r.tx[15:10] == scfs_pkg::INFO_MARK) && !r.info_pend)
    else $error("information frame mark wrong");

  normal_data_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (r.st == scfs_pkg::SCFS_IDLE && frame_start && !r.info_pend) |=>
      (r.tx[15:8] == $past(conversion_result_i)) && (r.tx[6:4] == $past(conversion_source_i)))
    else $error("normal frame data wrong");

  done_once_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (r.st == scfs_pkg::SCFS_IDLE && frame_start && !r.info_pend
     && r.done1_pend && !first_conversion_complete_i) |=>
      r.tx[0] && !r.done1_pend)
    else $error("done flag not sent exactly once");

  cal_latch_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cfg_decode |=> (r.cal[$past(r.rx[7:6])] == $past(r.rx[13:9])))
    else $error("calibration value not latched");

  sleep_cfg_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cfg_decode |=> (power_down_o == $past(r.rx[2])) && (conversion_slow_o == $past(r.rx[3])))
    else $error("sleep or speed field not taken");

  status_frame_request_set_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (cfg_decode && r.rx[1]) |=> r.info_pend)
    else $error("status frame request lost");

  normal_ignored_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (frame_end && !r.rx[0]) |=> $stable(r.cal) && $stable(r.style) && $stable(r.pdown))
    else $error("normal frame changed configuration");

  aux_split_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    low_side_aux_output_en_o != high_side_aux_output_en_o)
    else $error("both auxiliary groups enabled");

  aux_style_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cfg_decode |=>
      (low_side_aux_output_en_o == $past(r.rx[scfs_pkg::CFG_STYLE_BIT]))
      && (high_side_aux_output_en_o == !$past(r.rx[scfs_pkg::CFG_STYLE_BIT])))
    else $error("auxiliary group does not follow motor style");

endmodule : scfs_frame

`default_nettype wire

// ===== verif/scfs_host_model.sv
/*
  Host-side model of the four-wire serial master: shifts one frame out on
  mosi, MSB first, and collects the return frame from miso.
  Assumes clock_i is the bench clock; pins change by nonblocking assignment
  at its rising edges and all spacing is counted in its cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module scfs_host_model (
  input  wire logic clock_i,
  input  wire logic miso_i,
  output logic      serial_clk_o,
  output logic      chip_en_n_o,
  output logic      mosi_o
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    serial_clk_o = 1'b0;
    chip_en_n_o  = 1'b1;
    mosi_o       = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame; half sets the serial clock half period in clock_i cycles
  // ----------------------------------------------------------------
  // short frames are allowed on purpose to exercise the refusal path
  task automatic xfer(input logic [15:0] word, input int nbits, input int half,
                      output logic [15:0] reply);
    int i;
    reply = 16'h0000;
    chip_en_n_o <= 1'b0;
    repeat (half) @(posedge clock_i);
    for (i = 0; i < nbits; i++) begin
      mosi_o <= word[15 - i];
      repeat (half) @(posedge clock_i);
      serial_clk_o <= 1'b1;
      reply = {reply[14:0], miso_i};
      repeat (half) @(posedge clock_i);
      serial_clk_o <= 1'b0;
    end
    repeat (half) @(posedge clock_i);
    chip_en_n_o <= 1'b1;
    // released data line must not keep showing the last bit
    mosi_o      <= ~mosi_o;
    repeat (4 * half) @(posedge clock_i);
  endtask : xfer
endmodule : scfs_host_model

`default_nettype wire

// ===== verif/test_serial_config_and_status_frames.sv
/*
  Self-checking bench for scfs_frame: configuration frames from the host
  model, then normal and information return frames compared bit for bit.
  Assumes scfs_host_model and the design package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module test_serial_config_and_status_frames;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        sclk, ce_n, mosi, miso, miso_oe_n, miso_hold = 1'b0;
  logic        done1 = 1'b0, done2 = 1'b0, enc_a = 1'b1, enc_b = 1'b0;
  logic [7:0]  result = 8'ha5;
  logic [2:0]  source = 3'h5;
  logic [6:0]  flags = 7'h00;
  logic [4:0]  cal [4];
  logic [4:0]  cal_v [4] = '{5'h0a, 5'h15, 5'h03, 5'h1c};
  logic        filt, style, lo_en, hi_en, slow, pd, atest, enc_a_o, enc_b_o;
  logic [15:0] reply;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          s;

  always #2 clock_i = ~clock_i;

  // released miso does not hold its last value
  always @(posedge clock_i) if (!miso_oe_n) miso_hold <= ~miso;
  wire miso_line = miso_oe_n ? miso_hold : miso;

  scfs_host_model host (.clock_i(clock_i), .miso_i(miso_line), .serial_clk_o(sclk),
                        .chip_en_n_o(ce_n), .mosi_o(mosi));

  scfs_frame dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .serial_clk_i(sclk), .chip_en_n_i(ce_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(miso_oe_n),
    .conversion_result_i(result), .conversion_source_i(source),
    .first_conversion_complete_i(done1), .second_conversion_complete_i(done2),
    .encoder_phase_a_i(enc_a), .encoder_phase_b_i(enc_b),
    .external_reset_flag_i(flags[6]), .input_supply_low_flag_i(flags[5]),
    .five_volt_rail_low_i(flags[4]), .three_volt_rail_low_i(flags[3]),
    .core_rail_low_i(flags[2]), .overheat_trip_flag_i(flags[1]),
    .overheat_warn_flag_i(flags[0]),
    .cal_a_gain_o(cal[0]), .cal_a_offset_o(cal[1]), .cal_b_gain_o(cal[2]),
    .cal_b_offset_o(cal[3]), .encoder_filter_long_o(filt), .motor_c_style_o(style),
    .low_side_aux_output_en_o(lo_en), .high_side_aux_output_en_o(hi_en),
    .conversion_slow_o(slow), .power_down_o(pd), .analog_test_route_o(atest),
    .encoder_phase_a_o(enc_a_o), .encoder_phase_b_o(enc_b_o));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // option outputs packed as filter, style, low, high, slow, sleep, test route
  task automatic check_opts(input logic [6:0] exp);
    check("options", {9'h000, exp}, {9'h000, filt, style, lo_en, hi_en, slow, pd, atest});
  endtask : check_opts

  // test bits always one then zero
  function automatic logic [15:0] cfg(logic [4:0] c, logic a, logic [1:0] sel, logic [5:0] o);
    return {2'b10, c, a, sel, o};
  endfunction : cfg

  // half of 8 cycles gives the 64 ns serial clock
  task automatic frame(input logic [15:0] w, input int n = 16, input int half = 8);
    @(posedge clock_i);
    host.xfer(w, n, half, reply);
  endtask : frame

  task automatic pulse(input logic second);
    @(posedge clock_i);
    if (second) done2 <= 1'b1;
    else done1 <= 1'b1;
    @(posedge clock_i);
    done1 <= 1'b0;
    done2 <= 1'b0;
  endtask : pulse

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    check_opts(7'h08);
    check("miso enable", 16'h0001, {15'h0000, miso_oe_n});
    for (s = 0; s < 4; s++) begin
      frame(cfg(cal_v[s], 1'b1, s[1:0], 6'b111101));
    end
    for (s = 0; s < 4; s++) begin
      check("cal", {11'h000, cal_v[s]}, {11'h000, cal[s]});
    end
    check_opts(7'h77);
    frame(cfg(5'h1f, 1'b0, 2'h3, 6'b000001));
    check("cal b offset", 16'h001f, {11'h000, cal[3]});
    check_opts(7'h08);
    // non-configuration frame and short frame must leave everything alone
    frame(cfg(5'h00, 1'b1, 2'h0, 6'b111110));
    check_opts(7'h08);
    frame(cfg(5'h00, 1'b1, 2'h0, 6'b111101), 15);
    check("cal a gain", {11'h000, cal_v[0]}, {11'h000, cal[0]});
    check_opts(7'h08);
    pulse(1'b0);
    frame(16'h8000);
    check("normal frame", 16'ha555, reply);
    frame(16'h8000);
    check("done cleared", 16'ha554, reply);
    @(posedge clock_i) enc_b <= 1'b1;
    pulse(1'b1);
    frame(cfg(5'h1f, 1'b0, 2'h3, 6'b000011));
    check("second done", 16'ha556, reply);
    check("encoder", 16'h0003, {14'h0000, enc_b_o, enc_a_o});
    @(posedge clock_i) flags <= 7'b1010101;
    pulse(1'b0);
    frame(16'h8000);
    check("info frame", 16'h1add, reply);
    frame(16'h8000);
    check("normal after info", 16'ha55d, reply);
    wrap_up();
  end

  initial begin
    #50000;
    n_mismatch++;
    $display("[FAIL] run length expected end seen timeout");
    wrap_up();
  end
endmodule : test_serial_config_and_status_frames

`default_nettype wire
